// >>> hdl/fwd_irq_pkg.sv
`default_nettype none

package fwd_irq_pkg;

    // ****************************************************************
    // Register map: printed indices, byte address is four times each
    // ****************************************************************
    localparam logic [5:0] IDX_FWD_MODE_CTL = 6'h21;
    localparam logic [5:0] IDX_FWD_SYNC_STS = 6'h22;
    localparam logic [5:0] IDX_IRQ_EN_CTL   = 6'h23;
    localparam logic [5:0] IDX_IRQ_SRC_STS  = 6'h24;
    localparam int         ADDR_W           = 8;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_RR_FWD     = 0;
    localparam int BIT_SYNC_LO    = 2;
    localparam int BIT_SYNC_HI    = 3;
    localparam int BIT_SYNCED_NOW = 0;
    localparam int BIT_SYNC_FAIL  = 2;
    localparam int BIT_PORT0      = 0;
    localparam int BIT_PORT1      = 1;
    localparam int BIT_TX         = 4;
    localparam int BIT_GLOBAL     = 7;

    // ****************************************************************
    // Reset values and writable masks
    // ****************************************************************
    localparam logic [7:0] FWD_MODE_CTL_RESET = 8'h01;
    localparam logic [7:0] FWD_MODE_CTL_MASK  = 8'hCF;
    localparam logic [7:0] IRQ_EN_CTL_RESET   = 8'h00;
    localparam logic [7:0] IRQ_EN_CTL_MASK    = 8'h93;

    // Synchronized forwarding selections
    typedef enum logic [1:0] {
        SYNC_OFF        = 2'b00,
        SYNC_BASIC      = 2'b01,
        SYNC_INTERLEAVE = 2'b10,
        SYNC_CONCAT     = 2'b11
    } sync_mode_type;

    // APB request and answer
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_type;

    // Events from the forwarding engine and the port status logic
    typedef struct packed {
        logic engine_synced;
        logic frame_sent;
        logic sync_lost;
        logic tx_event;
        logic tx_status_read;
        logic port0_event;
        logic port0_status_read;
        logic port1_event;
        logic port1_status_read;
    } hub_event_type;

endpackage : fwd_irq_pkg

`default_nettype wire

// >>> hdl/forward_status_interrupt_agg.sv
// Function
// - Round robin bit resets set, no syncing
// - Sync failure flag only after good frame
// - Reading forwarding status clears failure flag
// - Synced bit follows engine, zero when disabled
// - Global enable gates interrupt line, resets off
// - Separate source enables for tx, ports
// - Global pending set by enabled pending sources
// - Tx pending cleared by transmitter status read
// - Port pending cleared by port status reads
// - Two bit field selects synchronized mode
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module forward_status_interrupt_agg (
    input  wire logic                      clk_in,
    input  wire logic                      rstn_in,
    input  wire fwd_irq_pkg::apb_req_type  apb_in,
    output var  fwd_irq_pkg::apb_rsp_type  apb_out,
    input  wire fwd_irq_pkg::hub_event_type events_in,
    output logic                           rotating_forward_enable_out,
    output logic [1:0]                     synced_forward_mode_out,
    output logic                           irq_out
);
    import fwd_irq_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0]  ctl;
        logic [7:0]  ie;
        logic        frame_ok;
        logic        sync_fail;
        logic        synced;
        logic        tx_pend;
        logic        port1_pend;
        logic        port0_pend;
        logic        irq;
        logic        fail_shown;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } state_type;

    state_type r;
    state_type next_r;

    logic          setup_phase;
    logic          access_done;
    logic [5:0]    index;
    logic          mapped;
    logic [7:0]    read_value;
    logic [7:0]    forwarding_sync_status_value;
    logic [7:0]    irq_sts_value;
    logic          global_pend;
    logic          next_global;
    sync_mode_type mode;

    // ****************************************************************
    // Decode and read mux
    // ****************************************************************
    // Setup captures the read word so prdata comes from a flop
    assign setup_phase = apb_in.psel && !apb_in.penable;
    assign access_done = apb_in.psel && apb_in.penable && r.pready;
    assign index       = apb_in.paddr[ADDR_W-1:2];
    assign mode        = sync_mode_type'(r.ctl[BIT_SYNC_HI:BIT_SYNC_LO]);
    assign global_pend = (r.tx_pend && r.ie[BIT_TX])
                       || (r.port1_pend && r.ie[BIT_PORT1])
                       || (r.port0_pend && r.ie[BIT_PORT0]);

    // Status words as software sees them
    always_comb begin
        forwarding_sync_status_value                 = 8'h00;
        forwarding_sync_status_value[BIT_SYNCED_NOW] = r.synced;
        forwarding_sync_status_value[BIT_SYNC_FAIL]  = r.sync_fail;
        irq_sts_value                 = 8'h00;
        irq_sts_value[BIT_GLOBAL]     = global_pend;
        irq_sts_value[BIT_TX]         = r.tx_pend;
        irq_sts_value[BIT_PORT1]      = r.port1_pend;
        irq_sts_value[BIT_PORT0]      = r.port0_pend;
    end

    // Address decode, unmapped words answer with an error and zero
    always_comb begin
        mapped     = 1'b1;
        read_value = 8'h00;
        case (index)
            IDX_FWD_MODE_CTL: begin
                read_value = r.ctl;
            end
            IDX_FWD_SYNC_STS: begin
                read_value = forwarding_sync_status_value;
            end
            IDX_IRQ_EN_CTL: begin
                read_value = r.ie;
            end
            IDX_IRQ_SRC_STS: begin
                read_value = irq_sts_value;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_r      = r;
        next_global = 1'b0;

        // Bus answer: one wait-free access phase after each setup
        next_r.pready = setup_phase;
        if (setup_phase) begin
            next_r.prdata     = {24'h000000, read_value};
            next_r.pslverr    = !mapped;
            next_r.fail_shown = !apb_in.pwrite && mapped
                && (index == IDX_FWD_SYNC_STS) && r.sync_fail;
        end

        // Register writes land at the completing edge only
        if (access_done && apb_in.pwrite) begin
            if (index == IDX_FWD_MODE_CTL) begin
                next_r.ctl = apb_in.pwdata[7:0] & FWD_MODE_CTL_MASK;
            end
            if (index == IDX_IRQ_EN_CTL) begin
                next_r.ie = apb_in.pwdata[7:0] & IRQ_EN_CTL_MASK;
            end
        end

        // Synced indication forced low while sync forwarding is off
        next_r.synced = events_in.engine_synced
            && (next_r.ctl[BIT_SYNC_HI:BIT_SYNC_LO] != SYNC_OFF);

        // A failure counts only once a synced frame has gone out
        if (mode == SYNC_OFF) begin
            next_r.frame_ok = 1'b0;
        end else if (events_in.frame_sent) begin
            next_r.frame_ok = 1'b1;
        end

        // Only a failure shown to the reader is cleared; set wins
        if (access_done && r.fail_shown) begin
            next_r.sync_fail = 1'b0;
        end
        if (events_in.sync_lost && (mode != SYNC_OFF) && r.frame_ok) begin
            next_r.sync_fail = 1'b1;
        end

        // Pending sources clear on their own status reads; set wins
        if (events_in.tx_status_read) begin
            next_r.tx_pend = 1'b0;
        end
        if (events_in.tx_event) begin
            next_r.tx_pend = 1'b1;
        end
        if (events_in.port1_status_read) begin
            next_r.port1_pend = 1'b0;
        end
        if (events_in.port1_event) begin
            next_r.port1_pend = 1'b1;
        end
        if (events_in.port0_status_read) begin
            next_r.port0_pend = 1'b0;
        end
        if (events_in.port0_event) begin
            next_r.port0_pend = 1'b1;
        end

        // Line follows next state so it matches the registers exactly
        next_global = (next_r.tx_pend && next_r.ie[BIT_TX])
                    || (next_r.port1_pend && next_r.ie[BIT_PORT1])
                    || (next_r.port0_pend && next_r.ie[BIT_PORT0]);
        next_r.irq  = next_global && next_r.ie[BIT_GLOBAL];
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            r            <= '0;
            r.ctl        <= FWD_MODE_CTL_RESET;
            r.ie         <= IRQ_EN_CTL_RESET;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flops; software must keep one mode at a time
    assign apb_out.prdata              = r.prdata;
    assign apb_out.pready              = r.pready;
    assign apb_out.pslverr             = r.pslverr;
    assign rotating_forward_enable_out = r.ctl[BIT_RR_FWD];
    assign synced_forward_mode_out     = r.ctl[BIT_SYNC_HI:BIT_SYNC_LO];
    assign irq_out                     = r.irq;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    rr_reset_a: assert property (
        !$past(rstn_in) |-> (rotating_forward_enable_out && synced_forward_mode_out == 2'b00
                             && r.ie == 8'h00))
        else $error("mode control not at reset value");

    fail_after_frame_a: assert property (
        $rose(r.sync_fail) |-> ($past(r.frame_ok) && $past(mode) != SYNC_OFF))
        else $error("sync failure set without a good frame");

    fail_read_clear_a: assert property (
        (access_done && r.fail_shown && !events_in.sync_lost) |=> !r.sync_fail)
        else $error("sync failure not cleared by read");

    fail_read_data_a: assert property (
        (setup_phase && !apb_in.pwrite && index == IDX_FWD_SYNC_STS && r.sync_fail)
        |=> apb_out.prdata[BIT_SYNC_FAIL])
        else $error("read missed the sync failure flag");

    synced_off_a: assert property (
        r.synced |-> (mode != SYNC_OFF))
        else $error("synced bit set while sync forwarding off");

    irq_gate_a: assert property (
        irq_out |-> r.ie[BIT_GLOBAL])
        else $error("interrupt driven while globally disabled");

    ie_write_a: assert property (
        (access_done && apb_in.pwrite && index == IDX_IRQ_EN_CTL)
        |=> (r.ie == ($past(apb_in.pwdata[7:0]) & IRQ_EN_CTL_MASK)))
        else $error("enable write not stored");

    global_read_a: assert property (
        (setup_phase && !apb_in.pwrite && index == IDX_IRQ_SRC_STS)
        |=> (apb_out.prdata[BIT_GLOBAL] == $past(global_pend)))
        else $error("global pending bit wrong on read");

    tx_hold_a: assert property (
        (r.tx_pend && !events_in.tx_status_read) |=> r.tx_pend)
        else $error("tx pending dropped without status read");

    port0_set_a: assert property (
        events_in.port0_event |=> r.port0_pend)
        else $error("port0 event lost");

    irq_match_a: assert property (
        irq_out == (global_pend && r.ie[BIT_GLOBAL]))
        else $error("interrupt line disagrees with pending and enable");

    ready_a: assert property (
        setup_phase |=> apb_out.pready ##1 !apb_out.pready)
        else $error("access phase not answered in one cycle");

    // ****************************************************************
    // Forwarding control and status checks
    // ****************************************************************
    // Mode word lands masked at the completing edge
    ctl_write_a: assert property (
        (access_done && apb_in.pwrite && index == IDX_FWD_MODE_CTL)
        |=> (r.ctl == ($past(apb_in.pwdata[7:0]) & FWD_MODE_CTL_MASK)))
        else $error("mode control write not stored");

    // Turning sync forwarding off drops the synced bit at once
    synced_drop_a: assert property (
        (access_done && apb_in.pwrite && index == IDX_FWD_MODE_CTL
         && apb_in.pwdata[BIT_SYNC_HI:BIT_SYNC_LO] == 2'b00) |=> !r.synced)
        else $error("synced bit survived sync forwarding off");

    // Engine level shows one cycle late while a sync mode stays on
    synced_follow_a: assert property (
        (mode != SYNC_OFF && !(access_done && apb_in.pwrite))
        |=> (r.synced == $past(events_in.engine_synced)))
        else $error("synced bit does not follow the engine");

    // Leaving sync forwarding forgets the good frame
    frame_forget_a: assert property (
        (mode == SYNC_OFF) |=> !r.frame_ok)
        else $error("good frame kept while sync forwarding off");

    // A failure after a good frame must be flagged
    fail_set_a: assert property (
        (events_in.sync_lost && mode != SYNC_OFF && r.frame_ok) |=> r.sync_fail)
        else $error("sync failure not flagged");

    // Failure stands until a read has shown it
    fail_hold_a: assert property (
        (r.sync_fail && !(access_done && r.fail_shown)) |=> r.sync_fail)
        else $error("sync failure dropped without a read");

    // ****************************************************************
    // Interrupt aggregation checks
    // ****************************************************************
    // Transmitter event latches until its status register is read
    tx_set_a: assert property (
        events_in.tx_event |=> r.tx_pend)
        else $error("tx event lost");

    tx_clear_a: assert property (
        (events_in.tx_status_read && !events_in.tx_event) |=> !r.tx_pend)
        else $error("tx pending not cleared by status read");

    // Port pending bits clear only on their own status reads
    port0_clear_a: assert property (
        (events_in.port0_status_read && !events_in.port0_event) |=> !r.port0_pend)
        else $error("port0 pending not cleared by status read");

    port1_set_a: assert property (
        events_in.port1_event |=> r.port1_pend)
        else $error("port1 event lost");

    port1_clear_a: assert property (
        (events_in.port1_status_read && !events_in.port1_event) |=> !r.port1_pend)
        else $error("port1 pending not cleared by status read");

    // No other read or write may drop a pending port
    port0_hold_a: assert property (
        (r.port0_pend && !events_in.port0_status_read) |=> r.port0_pend)
        else $error("port0 pending dropped without status read");

    port1_hold_a: assert property (
        (r.port1_pend && !events_in.port1_status_read) |=> r.port1_pend)
        else $error("port1 pending dropped without status read");

    // ****************************************************************
    // Bus answer checks
    // ****************************************************************
    // Unmapped words answer with an error and zero data
    unmapped_err_a: assert property (
        (setup_phase && !mapped) |=> (apb_out.pslverr && apb_out.prdata == 32'h0))
        else $error("unmapped access not refused");

    // ****************************************************************
    // Coverage
    // ****************************************************************
    // Failure set and cleared, line raised, refusal, concat mode
    fail_set_c: cover property ($rose(r.sync_fail));
    irq_rise_c: cover property ($rose(irq_out));
    fail_clear_c: cover property (access_done && r.fail_shown ##1 !r.sync_fail);
    unmapped_c: cover property (apb_out.pready && apb_out.pslverr);
    concat_mode_c: cover property (synced_forward_mode_out == 2'b11 && !rotating_forward_enable_out);

endmodule : forward_status_interrupt_agg

`default_nettype wire

// >>> sim/host_irq_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Host side of the interrupt line
// ****************************************************************
module host_irq_model (
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire logic       irq_in,
    output logic [7:0]      rises_out
);
    logic irq_q;

    // Count services; a level line held high must count only once
    always_ff @(posedge clk_in) begin
        irq_q <= irq_in;
        if (!rstn_in) begin
            rises_out <= 8'h00;
        end else if (irq_in && !irq_q) begin
            rises_out <= rises_out + 8'h01;
        end
    end
endmodule : host_irq_model

`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import fwd_irq_pkg::*;

    // ****************************************************************
    // Stimulus constants
    // ****************************************************************
    localparam logic [7:0] A_CTL = {IDX_FWD_MODE_CTL, 2'b00};
    localparam logic [7:0] A_STS = {IDX_FWD_SYNC_STS, 2'b00};
    localparam logic [7:0] A_IEC = {IDX_IRQ_EN_CTL, 2'b00};
    localparam logic [7:0] A_ISS = {IDX_IRQ_SRC_STS, 2'b00};
    localparam hub_event_type EV_TX   = '{tx_event: 1'b1, default: 1'b0};
    localparam hub_event_type EV_TXRD = '{tx_status_read: 1'b1, default: 1'b0};
    localparam hub_event_type EV_P0   = '{port0_event: 1'b1, default: 1'b0};
    localparam hub_event_type EV_P0RD = '{port0_status_read: 1'b1, default: 1'b0};
    localparam hub_event_type EV_P1   = '{port1_event: 1'b1, default: 1'b0};
    localparam hub_event_type EV_P1RD = '{port1_status_read: 1'b1, default: 1'b0};
    localparam hub_event_type EV_FRM  = '{frame_sent: 1'b1, default: 1'b0};
    localparam hub_event_type EV_LOST = '{sync_lost: 1'b1, default: 1'b0};

    logic          clk_in;
    logic          rstn_in;
    apb_req_type   apb;
    apb_rsp_type   rsp;
    hub_event_type ev;
    logic          rr;
    logic [1:0]    mode;
    logic          irq;
    logic [7:0]    rises;
    logic [31:0]   rd_q;
    logic          err_q;
    int            n_mismatch;
    int            checked;

    forward_status_interrupt_agg dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .apb_in(apb),
        .apb_out(rsp), .events_in(ev), .rotating_forward_enable_out(rr),
        .synced_forward_mode_out(mode), .irq_out(irq));
    host_irq_model host_u (.clk_in(clk_in), .rstn_in(rstn_in), .irq_in(irq), .rises_out(rises));

    always #5 clk_in = ~clk_in;

    // ****************************************************************
    // Bus and event tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // Request held until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk_in);
        apb.penable <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (rsp.pready !== 1'b1) chk(32'h0, 32'h1);
        rd_q = rsp.prdata;
        err_q = rsp.pslverr;
        apb <= '0;
    endtask : xfer

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd_q, {24'h0, exp});
        chk({31'h0, err_q}, 32'h0);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, {24'h0, d});
    endtask : wr

    task automatic pulse(input hub_event_type m);
        @(posedge clk_in);
        ev <= ev | m;
        @(posedge clk_in);
        ev <= ev & ~m;
    endtask : pulse

    task automatic irq_is(input logic e);
        @(negedge clk_in);
        chk({31'h0, irq}, {31'h0, e});
    endtask : irq_is

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    // Hang guard, far beyond the hundred and fifty or so cycles the tests need
    initial begin
        #50us;
        n_mismatch++;
        tally_and_finish();
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        clk_in = 1'b0;
        rstn_in = 1'b0;
        apb = '0;
        ev = '0;
        n_mismatch = 0;
        checked = 0;
        repeat (4) @(posedge clk_in);
        rstn_in <= 1'b1;
        chk({31'h0, rr}, 32'h1);
        chk({30'h0, mode}, 32'h0);
        rd(A_CTL, 8'h01);
        rd(A_STS, 8'h00);
        rd(A_IEC, 8'h00);
        rd(A_ISS, 8'h00);
        xfer(1'b0, 8'h00, 32'h0);
        chk({31'h0, err_q}, 32'h1);
        chk(rd_q, 32'h0);
        irq_is(1'b0);
        $display("test reset done");
        // Every mode; each sync mode is written with the rotating bit clear
        for (int i = 0; i < 4; i++) begin
            wr(A_CTL, i == 0 ? 8'h01 : {4'h0, i[1:0], 2'b00});
            @(negedge clk_in);
            chk({30'h0, mode}, i);
            chk({31'h0, rr}, {31'h0, (i == 0)});
        end
        $display("test modes done");
        wr(A_CTL, 8'h04);
        pulse(EV_LOST);
        rd(A_STS, 8'h00);
        pulse(EV_FRM);
        pulse(EV_LOST);
        rd(A_STS, 8'h04);
        rd(A_STS, 8'h00);
        @(posedge clk_in);
        ev.engine_synced <= 1'b1;
        rd(A_STS, 8'h01);
        wr(A_CTL, 8'h01);
        rd(A_STS, 8'h00);
        @(posedge clk_in);
        ev.engine_synced <= 1'b0;
        wr(A_CTL, 8'h08);
        pulse(EV_LOST);
        rd(A_STS, 8'h00);
        $display("test sync status done");
        wr(A_IEC, 8'h13);
        pulse(EV_TX);
        irq_is(1'b0);
        rd(A_ISS, 8'h90);
        wr(A_IEC, 8'h93);
        irq_is(1'b1);
        pulse(EV_TXRD);
        irq_is(1'b0);
        rd(A_ISS, 8'h00);
        wr(A_IEC, 8'h82);
        pulse(EV_P0);
        irq_is(1'b0);
        rd(A_ISS, 8'h01);
        pulse(EV_P1);
        irq_is(1'b1);
        rd(A_ISS, 8'h83);
        pulse(EV_P1RD);
        rd(A_ISS, 8'h01);
        irq_is(1'b0);
        pulse(EV_P0RD);
        rd(A_ISS, 8'h00);
        chk({24'h0, rises}, 32'h2);
        $display("test interrupts done");
        // Bits outside the writable masks read zero, status words ignore writes
        wr(A_CTL, 8'hFE);
        rd(A_CTL, 8'hCE);
        wr(A_IEC, 8'hFF);
        rd(A_IEC, 8'h93);
        wr(A_ISS, 8'hFF);
        rd(A_ISS, 8'h00);
        wr(A_STS, 8'hFF);
        rd(A_STS, 8'h00);
        irq_is(1'b0);
        $display("test reserved done");
        tally_and_finish();
    end
endmodule : tb_top

`default_nettype wire
